// ==== i2cm_params.svh ====
// constants for the two-wire master: offsets, field positions, reset values, timing
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define I2CM_TX_ADDR 8'h9A
`define I2CM_RX_ADDR 8'h9B
`define I2CM_MODE_ADDR 8'hE8
`define I2CM_TADR_ADDR 8'hE9
`define I2CM_STAT_ADDR 8'hEA
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define I2CM_MODE_RST 8'h00
`define I2CM_TADR_RST 8'h00
`define I2CM_RX_RST 8'h00
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define I2CM_EN_BIT 7
`define I2CM_RATE_HI 6
`define I2CM_RATE_LO 5
`define I2CM_RCT_HI 4
`define I2CM_RCT_LO 0
`define I2CM_DIR_BIT 0
`define I2CM_ST_BUSY 7
`define I2CM_ST_NOACK 6
`define I2CM_ST_RXIRQ 5
`define I2CM_ST_TXIRQ 4
`define I2CM_ST_FIFO_HI 3
`define I2CM_ST_FIFO_LO 2
`define I2CM_ST_ACC 1
`define I2CM_ST_TXWR 0
// ------------------------------------------------------------
// timing: serial clock period in core cycles at rate code 0, phases per period; fifo depth
// ------------------------------------------------------------
`define I2CM_DIV_BASE 16
`define I2CM_PHASES 4
`define I2CM_FIFO_DEPTH 4
`endif

// ==== i2cm_pkg.sv ====
// types shared by the two-wire master files
package i2cm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BYTE,
    ST_STOP,
    ST_RESTART
  } i2cm_state_e;
endpackage

// ==== i2cm_fifo.sv ====
// small byte fifo with registered head output
`timescale 1ns/100ps
`include "i2cm_params.svh"
module i2cm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `I2CM_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW-1:0] rd_nxt;
  logic do_push;
  logic do_pop;

  assign do_push = push && (count_r != (AW+1)'(DEPTH));
  assign do_pop = pop && (count_r != '0);
  assign rd_nxt = do_pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
  assign count = count_r;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr_r] <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      end
      rd_ptr_r <= rd_nxt;
      count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // forward a write landing on the new head so rdata never lags count
  always_ff @(posedge clk_sys) begin
    if (reset || clear) begin
      rdata <= '0;
    end else if (do_push && wr_ptr_r == rd_nxt) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[rd_nxt];
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (reset) count_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  fifo_full_a: assert property (@(posedge clk_sys) disable iff (reset)
    (count_r == (AW+1)'(DEPTH) && push && !pop && !clear) |=> count_r == (AW+1)'(DEPTH))
    else $error("push into full fifo changed count");
endmodule

// ==== i2cm_clkdiv.sv ====
// quarter-bit tick generator for the serial clock
`timescale 1ns/100ps
`include "i2cm_params.svh"
module i2cm_clkdiv (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] rate,
  output logic tick
);
  // four ticks per serial clock period: divisor 16, 32, 64 or 128
  localparam logic [5:0] QTR = 6'(`I2CM_DIV_BASE / `I2CM_PHASES);
  logic [5:0] cnt_r;
  logic [5:0] reload;

  assign reload = 6'((QTR << rate) - 6'h01);
  assign tick = run && (cnt_r == 6'h00);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 6'h00;
    end else if (!run || cnt_r == 6'h00) begin
      cnt_r <= reload;
    end else begin
      cnt_r <= cnt_r - 6'h01;
    end
  end

  tick_space_a: assert property (@(posedge clk_sys) disable iff (reset) tick |=> !tick [*3])
    else $error("quarter ticks closer than four cycles");
endmodule

// ==== i2cm_master.sv ====
// two-wire bus master with special function register access and shared pins
// Summary of operation
// - master only in hardware; no slave behaviour exists.
// - pin select input gives the shared pins to this master or the spi port.
// - bus lines only pulled low or released, wired-and.
// - start only on idle bus; start, address, data, stop returns idle.
// - serial clock is core clock over 16 times two to the rate code.
// - at 4.096 MHz core, rate codes give 256 kHz down to 32 kHz.
// - active only while enable bit set; address write then launches transfer.
// - target address holds seven-bit id high and direction bit low.
// - every target address write while active starts a new read or write.
// - direction one reads; received bytes go to the receive buffer.
// - direction zero writes bytes taken from the transmit buffer.
// - read stops after receive count plus one bytes, or on error.
// - registers sit at the shared spi offsets; buffers are common.
// - missing acknowledge sets sticky flag and halts; write zero clears.
// - master acks reads automatically, nacks the last byte.
// - address rewrite mid-transfer ends with repeated start, then continues.
// - four-byte receive and transmit fifos; only the one in use is reported in status.
`timescale 1ns/100ps
`include "i2cm_params.svh"
module i2cm_master #(
  parameter int FIFO_DEPTH = `I2CM_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic peripheral_pin_select,
  input wire logic spi_data_out,
  input wire logic spi_data_oe_n,
  input wire logic spi_clk_out,
  input wire logic spi_clk_oe_n,
  input wire logic bus_data_line_in,
  output logic bus_data_line_out,
  output logic bus_data_line_oe_n,
  input wire logic bus_clock_line_in,
  output logic bus_clock_line_out,
  output logic bus_clock_line_oe_n
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CW-1:0] FULL = CW'(FIFO_DEPTH);

  // ------------------------------------------------------------
  // registers and decode
  // ------------------------------------------------------------
  logic [7:0] two_wire_mode_r;
  logic [7:0] target_address_r;
  logic [4:0] flags_r;
  logic [4:0] flags_set;
  logic [4:0] flags_clr;
  logic go_r;
  logic two_wire_enable;
  logic active;
  logic [1:0] clock_rate_field;
  logic [4:0] receive_count_field;
  logic adr_wr;
  logic mode_wr;
  logic stat_wr;
  logic tx_wr;
  logic rx_rd;

  assign two_wire_enable = two_wire_mode_r[`I2CM_EN_BIT];
  assign clock_rate_field = two_wire_mode_r[`I2CM_RATE_HI:`I2CM_RATE_LO];
  assign receive_count_field = two_wire_mode_r[`I2CM_RCT_HI:`I2CM_RCT_LO];
  assign active = two_wire_enable && peripheral_pin_select;
  assign adr_wr = sfr_wr && sfr_addr == `I2CM_TADR_ADDR;
  assign mode_wr = sfr_wr && sfr_addr == `I2CM_MODE_ADDR;
  assign stat_wr = sfr_wr && sfr_addr == `I2CM_STAT_ADDR;
  assign tx_wr = sfr_wr && sfr_addr == `I2CM_TX_ADDR;
  assign rx_rd = sfr_rd && sfr_addr == `I2CM_RX_ADDR;

  // ------------------------------------------------------------
  // transfer engine signals
  // ------------------------------------------------------------
  i2cm_pkg::i2cm_state_e state_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic is_addr_r;
  logic rd_r;
  logic [4:0] rxcnt_r;
  logic ack_in_r;
  logic sda_low_r;
  logic scl_low_r;
  logic tick;
  logic adv;
  logic stall;
  logic tx_mode;
  logic rx_last;
  logic byte_end;
  logic nack_evt;
  logic load_next;
  logic rx_push;
  logic tx_push;
  logic tx_pop;
  logic [7:0] tx_rdata;
  logic [7:0] rx_rdata;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] use_cnt;
  logic [1:0] fifo_stat;
  logic i2c_sda_oe_n;
  logic i2c_scl_oe_n;

  assign tx_mode = is_addr_r || !rd_r;
  assign rx_last = rxcnt_r == receive_count_field;
  // slave may stretch the clock; a full receive fifo holds scl released in the acknowledge bit instead of dropping a byte
  assign stall = state_r == i2cm_pkg::ST_BYTE
    && ((phase_r == 2'h2 && !bus_clock_line_in)
    || (phase_r == 2'h3 && bit_r[3] && !tx_mode && rx_cnt == FULL));
  assign adv = tick && !stall;
  assign byte_end = adv && state_r == i2cm_pkg::ST_BYTE && phase_r == 2'h3 && bit_r[3];
  assign nack_evt = byte_end && tx_mode && ack_in_r;
  assign load_next = byte_end && tx_mode && !ack_in_r && !(is_addr_r && rd_r) && !go_r
    && tx_cnt != '0;
  assign rx_push = byte_end && !tx_mode;
  assign tx_push = tx_wr && tx_cnt != FULL;
  assign tx_pop = load_next;

  i2cm_clkdiv u_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(active && state_r != i2cm_pkg::ST_IDLE),
    .rate(clock_rate_field),
    .tick(tick)
  );

  i2cm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(!two_wire_enable),
    .push(tx_push),
    .wdata(sfr_wdata),
    .pop(tx_pop),
    .rdata(tx_rdata),
    .count(tx_cnt)
  );

  i2cm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxf (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(!two_wire_enable),
    .push(rx_push),
    .wdata(shift_r),
    .pop(rx_rd),
    .rdata(rx_rdata),
    .count(rx_cnt)
  );

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      two_wire_mode_r <= `I2CM_MODE_RST;
    end else if (mode_wr) begin
      two_wire_mode_r <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      target_address_r <= `I2CM_TADR_RST;
    end else if (adr_wr) begin
      target_address_r <= sfr_wdata;
    end
  end

  // a new address write beats the clear from the start that consumes the old one
  always_ff @(posedge clk_sys) begin
    if (reset || !active) begin
      go_r <= 1'b0;
    end else if (adr_wr) begin
      go_r <= 1'b1;
    end else if (adv && state_r == i2cm_pkg::ST_START && phase_r == 2'h3) begin
      go_r <= 1'b0;
    end
  end

  // sticky flags {noack, rxirq, txirq, acc_err, txwr_err}; writing 0 clears, set wins
  assign flags_set = {nack_evt, rx_push, tx_pop && tx_cnt == CW'(1),
    tx_wr && state_r != i2cm_pkg::ST_IDLE && !tx_mode, tx_wr && tx_cnt == FULL};
  assign flags_clr = stat_wr ? ~{sfr_wdata[`I2CM_ST_NOACK], sfr_wdata[`I2CM_ST_RXIRQ],
    sfr_wdata[`I2CM_ST_TXIRQ], sfr_wdata[`I2CM_ST_ACC], sfr_wdata[`I2CM_ST_TXWR]} : 5'h00;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_r <= 5'h00;
    end else begin
      flags_r <= flags_set | (flags_r & ~flags_clr);
    end
  end

  // only the fifo of the current direction is reported
  assign use_cnt = rd_r ? rx_cnt : tx_cnt;
  assign fifo_stat = (use_cnt == '0) ? 2'h0 : (use_cnt == FULL) ? 2'h3 : 2'h2;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sfr_rdata <= `I2CM_RX_RST;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `I2CM_RX_ADDR: sfr_rdata <= rx_rdata;
        `I2CM_MODE_ADDR: sfr_rdata <= two_wire_mode_r;
        `I2CM_TADR_ADDR: sfr_rdata <= target_address_r;
        `I2CM_STAT_ADDR: sfr_rdata <= {state_r != i2cm_pkg::ST_IDLE || go_r, flags_r[4:2],
          fifo_stat, flags_r[1:0]};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // bus sequencer: four quarter-bit phases per step
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset || !active) begin
      state_r <= i2cm_pkg::ST_IDLE;
      phase_r <= 2'h0;
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      is_addr_r <= 1'b0;
      rd_r <= 1'b0;
      rxcnt_r <= 5'h00;
      ack_in_r <= 1'b0;
    end else if (state_r == i2cm_pkg::ST_IDLE) begin
      phase_r <= 2'h0;
      if (go_r && bus_data_line_in && bus_clock_line_in) begin
        state_r <= i2cm_pkg::ST_START;
      end
    end else if (adv) begin
      phase_r <= phase_r + 2'h1;
      case (state_r)
        i2cm_pkg::ST_START: begin
          if (phase_r == 2'h1) begin
            sda_low_r <= 1'b1;
          end else if (phase_r == 2'h2) begin
            scl_low_r <= 1'b1;
          end else if (phase_r == 2'h3) begin
            shift_r <= target_address_r;
            rd_r <= target_address_r[`I2CM_DIR_BIT];
            is_addr_r <= 1'b1;
            bit_r <= 4'h0;
            rxcnt_r <= 5'h00;
            state_r <= i2cm_pkg::ST_BYTE;
          end
        end
        i2cm_pkg::ST_BYTE: begin
          case (phase_r)
            2'h0: sda_low_r <= bit_r[3] ? (!tx_mode && !rx_last) : (tx_mode && !shift_r[7]);
            2'h1: scl_low_r <= 1'b0;
            2'h2: begin
              ack_in_r <= bus_data_line_in;
              if (!bit_r[3]) begin
                shift_r <= {shift_r[6:0], bus_data_line_in};
              end
            end
            default: begin
              scl_low_r <= 1'b1;
              if (!bit_r[3]) begin
                bit_r <= bit_r + 4'h1;
              end else if (tx_mode) begin
                if (ack_in_r) begin
                  state_r <= i2cm_pkg::ST_STOP;
                end else if (is_addr_r && rd_r) begin
                  is_addr_r <= 1'b0;
                  bit_r <= 4'h0;
                end else if (go_r) begin
                  state_r <= i2cm_pkg::ST_RESTART;
                end else if (load_next) begin
                  shift_r <= tx_rdata;
                  is_addr_r <= 1'b0;
                  bit_r <= 4'h0;
                end else begin
                  state_r <= i2cm_pkg::ST_STOP;
                end
              end else begin
                bit_r <= 4'h0;
                rxcnt_r <= rxcnt_r + 5'h01;
                if (rx_last) begin
                  state_r <= go_r ? i2cm_pkg::ST_RESTART : i2cm_pkg::ST_STOP;
                end
              end
            end
          endcase
        end
        i2cm_pkg::ST_STOP: begin
          if (phase_r == 2'h0) begin
            sda_low_r <= 1'b1;
          end else if (phase_r == 2'h1) begin
            scl_low_r <= 1'b0;
          end else if (phase_r == 2'h2) begin
            sda_low_r <= 1'b0;
          end else begin
            state_r <= i2cm_pkg::ST_IDLE;
          end
        end
        i2cm_pkg::ST_RESTART: begin
          if (phase_r == 2'h0) begin
            sda_low_r <= 1'b0;
          end else if (phase_r == 2'h1) begin
            scl_low_r <= 1'b0;
            state_r <= i2cm_pkg::ST_START;
            phase_r <= 2'h1;
          end
        end
        default: state_r <= i2cm_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pins: this master only ever pulls low; spi owns them when deselected
  // ------------------------------------------------------------
  assign i2c_sda_oe_n = !(active && sda_low_r);
  assign i2c_scl_oe_n = !(active && scl_low_r);
  assign bus_data_line_out = peripheral_pin_select ? 1'b0 : spi_data_out;
  assign bus_data_line_oe_n = peripheral_pin_select ? i2c_sda_oe_n : spi_data_oe_n;
  assign bus_clock_line_out = peripheral_pin_select ? 1'b0 : spi_clk_out;
  assign bus_clock_line_oe_n = peripheral_pin_select ? i2c_scl_oe_n : spi_clk_oe_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_start_drop;
    state_r == i2cm_pkg::ST_START && adv && phase_r == 2'h1 ##1 !i2c_sda_oe_n && i2c_scl_oe_n;
  endsequence
  sequence s_nack;
    nack_evt && active;
  endsequence

  lines_release_a: assert property (!active |-> i2c_sda_oe_n && i2c_scl_oe_n)
    else $error("lines held while inactive");
  wired_and_a: assert property (peripheral_pin_select |->
    !bus_data_line_out && !bus_clock_line_out && bus_data_line_oe_n == i2c_sda_oe_n)
    else $error("selected pins not wired-and");
  start_idle_a: assert property ((state_r == i2cm_pkg::ST_IDLE ##1 state_r == i2cm_pkg::ST_START)
    |-> $past(bus_data_line_in && bus_clock_line_in))
    else $error("start on busy bus");
  start_cond_a: assert property ((state_r == i2cm_pkg::ST_START && adv && phase_r == 2'h1 && active)
    |-> s_start_drop)
    else $error("start condition malformed");
  nack_halt_a: assert property (s_nack |=> flags_r[4] && state_r == i2cm_pkg::ST_STOP)
    else $error("missing ack not flagged or not halted");
  addr_launch_a: assert property ((adr_wr && active) |=> go_r)
    else $error("address write did not launch");
  rx_ack_a: assert property ((state_r == i2cm_pkg::ST_BYTE && adv && phase_r == 2'h0 && bit_r[3]
    && !tx_mode && active) |=> sda_low_r != $past(rx_last))
    else $error("wrong master ack on read");
  rx_stop_a: assert property ((rx_push && rx_last && active) |=> state_r == i2cm_pkg::ST_STOP
    || state_r == i2cm_pkg::ST_RESTART)
    else $error("read did not end after count");
endmodule

// ==== i2cm_slave_model.sv ====
// behavioural two-wire slave answering one identity, with optional clock stretch
`timescale 1ns/100ps
module i2cm_slave_model #(
  parameter logic [6:0] OWN_ID = 7'h2C,
  parameter logic [7:0] RD_BASE = 8'h3C
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic sda_oe_n,
  output logic scl_oe_n,
  output logic [7:0] last_byte,
  output logic [7:0] wr_count,
  output logic [7:0] ack_count,
  output logic nack_seen
);
  logic [7:0] shreg;
  logic [7:0] rd_idx;
  logic active = 1'b0;
  logic rd = 1'b0;
  logic adr_ph = 1'b0;
  int bitn = 0;
  initial begin
    sda_oe_n = 1'b1;
    scl_oe_n = 1'b1;
  end
  // ----------------------------------------
  // start and stop seen on the wire
  // ----------------------------------------
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    adr_ph = 1'b1;
    bitn = 0;
    rd_idx = 8'h00;
    wr_count = 8'h00;
    ack_count = 8'h00;
    nack_seen = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    sda_oe_n = 1'b1;
  end
  // ----------------------------------------
  // bit sampling and driving
  // ----------------------------------------
  // one shift register serves both ways: driven data bit is always shreg[7]
  always @(posedge scl) if (active) begin
    if (bitn < 8) begin
      shreg = {shreg[6:0], sda};
      bitn++;
    end else begin
      bitn = 9;
      if (rd && !adr_ph && sda) nack_seen = 1'b1;
      else if (rd && !adr_ph) ack_count++;
    end
  end
  always @(negedge scl) if (active) begin
    if (bitn == 8) begin
      if (adr_ph) begin
        rd = shreg[0];
        active = (shreg[7:1] == OWN_ID);
        sda_oe_n = !active;
      end else if (!rd) begin
        last_byte = shreg;
        wr_count++;
        sda_oe_n = 1'b0;
      end else sda_oe_n = 1'b1;
      // slow slave: hold the clock low through the acknowledge
      if (stretch) begin
        scl_oe_n = 1'b0;
        #2000 scl_oe_n = 1'b1;
      end
    end else if (bitn == 9) begin
      bitn = 0;
      adr_ph = 1'b0;
      if (nack_seen) active = 1'b0;
      if (rd && !nack_seen) shreg = RD_BASE + rd_idx;
      if (rd && !nack_seen) rd_idx++;
      sda_oe_n = (rd && !nack_seen) ? shreg[7] : 1'b1;
    end else if (rd && !adr_ph) sda_oe_n = shreg[7];
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for the two-wire master and its registers
`timescale 1ns/100ps
`include "i2cm_params.svh"
module testbench;
  localparam logic [6:0] SLV_ID = 7'h2C;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic pin_sel = 1'b1;
  logic spi_do = 1'b1;
  logic spi_do_oe_n = 1'b1;
  logic stretch = 1'b0;
  logic sda_out, sda_oe_n, scl_out, scl_oe_n, slv_sda_oe_n, slv_scl_oe_n, slv_nack;
  logic [7:0] slv_last, slv_wcount, slv_acks, rd_v;
  wire sda = ((!sda_oe_n && !sda_out) || !slv_sda_oe_n) ? 1'b0 : 1'b1;
  wire scl = ((!scl_oe_n && !scl_out) || !slv_scl_oe_n) ? 1'b0 : 1'b1;
  int err_total = 0;
  int total_checks = 0;
  int starts = 0, stops = 0, sclk_n = 0, s0 = 0, p0 = 0;
  realtime t_first, period;

  i2cm_master i_dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .peripheral_pin_select(pin_sel),
    .spi_data_out(spi_do), .spi_data_oe_n(spi_do_oe_n), .spi_clk_out(!spi_do), .spi_clk_oe_n(spi_do_oe_n),
    .bus_data_line_in(sda), .bus_data_line_out(sda_out), .bus_data_line_oe_n(sda_oe_n),
    .bus_clock_line_in(scl), .bus_clock_line_out(scl_out), .bus_clock_line_oe_n(scl_oe_n));
  i2cm_slave_model #(.OWN_ID(SLV_ID), .RD_BASE(8'h3C)) i_slave (.scl(scl), .sda(sda), .stretch(stretch),
    .sda_oe_n(slv_sda_oe_n), .scl_oe_n(slv_scl_oe_n), .last_byte(slv_last), .wr_count(slv_wcount),
    .ack_count(slv_acks), .nack_seen(slv_nack));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // wire monitor: starts, stops, clock period
  // ----------------------------------------
  always @(negedge sda) if (scl === 1'b1) begin
    starts++;
    sclk_n = 0;
  end
  always @(posedge sda) if (scl === 1'b1) stops++;
  always @(posedge scl) begin
    sclk_n++;
    if (sclk_n == 1) t_first = $realtime;
    if (sclk_n == 2) period = $realtime - t_first;
  end
  // ----------------------------------------
  // register access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one idle cycle after each strobe keeps the driver from toggling twice in a step
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #1 sfr_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #1 sfr_rd = 1'b0;
    @(posedge clk_sys);
    #1 d = sfr_rdata;
  endtask
  task automatic rcheck(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sfr_read(a, d);
    check(what, exp, d);
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 3000; i++) begin
      sfr_read(`I2CM_STAT_ADDR, s);
      if (s[7] === 1'b0) return;
    end
    check("busy", 8'h00, {7'h00, s[7]});
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #5_000_000;
    err_total++;
    report_and_stop();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    rcheck("mode", `I2CM_MODE_ADDR, 8'h00);
    rcheck("target", `I2CM_TADR_ADDR, 8'h00);
    rcheck("status", `I2CM_STAT_ADDR, 8'h00);
    rcheck("rx", `I2CM_RX_ADDR, 8'h00);
    rcheck("unmapped", 8'h00, 8'h00);
    s0 = starts;
    sfr_write(`I2CM_TADR_ADDR, {SLV_ID, 1'b0});
    repeat (40) @(posedge clk_sys);
    #1 check("start off", 8'h00, 8'(starts - s0));
    check("oe off", 8'h03, {6'h00, sda_oe_n, scl_oe_n});
    rcheck("target rb", `I2CM_TADR_ADDR, {SLV_ID, 1'b0});
    pin_sel = 1'b0;
    spi_do = 1'b0;
    spi_do_oe_n = 1'b0;
    @(posedge clk_sys);
    #1 check("spi pins", 8'h02, {4'h0, sda_out, sda_oe_n, scl_out, scl_oe_n});
    check("spi wire", 8'h00, {7'h00, sda});
    pin_sel = 1'b1;
    spi_do_oe_n = 1'b1;
    @(posedge clk_sys);
    #1 check("own out", 8'h00, {6'h00, sda_out, scl_out});
    for (int r = 0; r < 4; r++) begin
      sfr_write(`I2CM_MODE_ADDR, {1'b1, r[1:0], 5'h00});
      sfr_write(`I2CM_TX_ADDR, 8'h50 + 8'(r));
      sfr_write(`I2CM_TX_ADDR, 8'hA0);
      sfr_write(`I2CM_TADR_ADDR, {SLV_ID, 1'b0});
      wait_idle();
      check("period", 8'h10 << r, 8'(int'(period / 100.0)));
      check("wr count", 8'h02, slv_wcount);
      check("last wr", 8'hA0, slv_last);
      sfr_read(`I2CM_STAT_ADDR, rd_v);
      check("txirq", 8'h01, {7'h00, rd_v[4]});
    end
    sfr_write(`I2CM_MODE_ADDR, 8'h80);
    sfr_write(`I2CM_STAT_ADDR, 8'h00);
    sfr_write(`I2CM_TX_ADDR, 8'h77);
    sfr_write(`I2CM_TADR_ADDR, {SLV_ID ^ 7'h01, 1'b0});
    wait_idle();
    sfr_read(`I2CM_STAT_ADDR, rd_v);
    check("noack", 8'h01, {7'h00, rd_v[6]});
    check("no data", 8'h00, slv_wcount);
    sfr_write(`I2CM_STAT_ADDR, 8'h00);
    sfr_read(`I2CM_STAT_ADDR, rd_v);
    check("noack clr", 8'h00, {7'h00, rd_v[6]});
    sfr_write(`I2CM_MODE_ADDR, 8'h00);
    sfr_write(`I2CM_MODE_ADDR, 8'h82);
    rcheck("mode rb", `I2CM_MODE_ADDR, 8'h82);
    sfr_write(`I2CM_STAT_ADDR, 8'h00);
    stretch = 1'b1;
    sfr_write(`I2CM_TADR_ADDR, {SLV_ID, 1'b1});
    // past the nine address clocks, so the write falls in the read data phase
    repeat (10) @(posedge scl);
    @(posedge clk_sys);
    #1 sfr_write(`I2CM_TX_ADDR, 8'hEE);
    wait_idle();
    stretch = 1'b0;
    rcheck("rx status", `I2CM_STAT_ADDR, 8'h2A);
    check("master acks", 8'h02, slv_acks);
    check("last nack", 8'h01, {7'h00, slv_nack});
    for (int i = 0; i < 3; i++) rcheck("rx byte", `I2CM_RX_ADDR, 8'h3C + 8'(i));
    sfr_write(`I2CM_MODE_ADDR, 8'h00);
    sfr_write(`I2CM_MODE_ADDR, 8'h80);
    sfr_write(`I2CM_TX_ADDR, 8'h12);
    sfr_write(`I2CM_TX_ADDR, 8'h34);
    s0 = starts;
    p0 = stops;
    sfr_write(`I2CM_TADR_ADDR, {SLV_ID, 1'b0});
    repeat (3) @(posedge scl);
    @(posedge clk_sys);
    #1 sfr_write(`I2CM_TADR_ADDR, {SLV_ID, 1'b1});
    wait_idle();
    check("restarts", 8'h02, 8'(starts - s0));
    check("stops", 8'h01, 8'(stops - p0));
    rcheck("rx after rs", `I2CM_RX_ADDR, 8'h3C);
    sfr_write(`I2CM_MODE_ADDR, 8'h00);
    sfr_write(`I2CM_TADR_ADDR, {SLV_ID, 1'b0});
    sfr_write(`I2CM_MODE_ADDR, 8'h80);
    sfr_write(`I2CM_STAT_ADDR, 8'h00);
    for (int i = 0; i < 5; i++) sfr_write(`I2CM_TX_ADDR, 8'h11 + 8'(i));
    rcheck("tx full", `I2CM_STAT_ADDR, 8'h0D);
    sfr_write(`I2CM_MODE_ADDR, 8'h00);
    rcheck("tx cleared", `I2CM_STAT_ADDR, 8'h01);
    report_and_stop();
  end
endmodule
